// file: pkg/ees_defs.svh
// Function
// - host alone masters, clocks every transfer
// - link clock at most 500 kHz
// - data changes only while clock low
// - data edge during clock high is condition
// - start: data falls while clock high
// - stop: data rises while clock high
// - every transfer opens start, closes stop
// - start wakes memory, stop returns standby
// - receiver pulls data low during ninth clock
// - host clocks the acknowledge bit always
// - no acknowledge: memory stops sending, releases
// - host ends reads with nack, stop
// - memory releases data line in standby
// - control byte: row, order mode, direction
// - direction zero writes, one reads
// - 32 rows of 16 bits, row selected
// - memory times its programming itself
// - write: control, zero to two bytes, stop
// - read steps row after word, wraps
// - read: acknowledge, load word, send byte
// - host may force known state by dummy write
`ifndef EES_DEFS_SVH
`define EES_DEFS_SVH

// ==========================================
// array geometry and control byte layout
`define EES_ROWS            32
`define EES_WORD_W          16
`define EES_ROW_LSB         3
`define EES_MODE_LSB        1
`define EES_DIR_POS         0
`define EES_DIR_READ        1'b1
`define EES_MODE_LO_FIRST   2'h1
`define EES_MODE_HI_FIRST   2'h2
`define EES_MODE_FILL0      2'h0
`define EES_MODE_FILL1      2'h3
`define EES_BYTE_LAST       3'h7
`define EES_ACK_BIT         4'h8
`define EES_MAX_WR_BYTES    2'h2

// ==========================================
// timing
`define EES_CLK_PERIOD_NS   10
`define EES_LINK_PERIOD_NS  15
`define EES_SCL_MAX_KHZ     500
`define EES_SCL_QTR_CYC     ((1000000 / `EES_SCL_MAX_KHZ / 4 + `EES_CLK_PERIOD_NS - 1) / `EES_CLK_PERIOD_NS)
`define EES_ERASE_TIME_NS   3000
`define EES_WRITE_TIME_NS   3000
`define EES_ERASE_CYC       ((`EES_ERASE_TIME_NS + `EES_LINK_PERIOD_NS - 1) / `EES_LINK_PERIOD_NS)
`define EES_WRITE_CYC       ((`EES_WRITE_TIME_NS + `EES_LINK_PERIOD_NS - 1) / `EES_LINK_PERIOD_NS)

`endif

// file: pkg/ees_pkg.sv
package ees_pkg;

	// ==========================================
	// memory link states
	typedef enum logic [7:0] {
		DEV_STANDBY = 8'h01,
		DEV_CTRL    = 8'h02,
		DEV_ACK_C   = 8'h04,
		DEV_WRX     = 8'h08,
		DEV_ACK_W   = 8'h10,
		DEV_TX      = 8'h20,
		DEV_ACK_R   = 8'h40,
		DEV_IGNORE  = 8'h80
	} ees_dev_state_t;

	// ==========================================
	// programming states
	typedef enum logic [2:0] {
		PRG_IDLE  = 3'h1,
		PRG_ERASE = 3'h2,
		PRG_WRITE = 3'h4
	} ees_prog_state_t;

	// ==========================================
	// host states
	typedef enum logic [3:0] {
		HST_IDLE  = 4'h1,
		HST_START = 4'h2,
		HST_BIT   = 4'h4,
		HST_STOP  = 4'h8
	} ees_host_state_t;

endpackage

// file: pkg/ees_link_if.sv
`timescale 1ns/10ps
// ==========================================
// two-wire link, data line pulled up
interface ees_link_if;
	logic scl;          // serial clock from host
	logic host_sda_oe;  // host pulls data low
	logic dev_sda_oe;   // memory pulls data low
	logic sda;          // resolved data line

	// wired-and with pull-up
	assign sda = ~(host_sda_oe | dev_sda_oe);

	modport host (output scl, output host_sda_oe, input sda);
	modport dev  (input scl, input sda, output dev_sda_oe);
endinterface // ees_link_if

// file: verilog/ees_mem.sv
`timescale 1ns/10ps
`include "ees_defs.svh"
// ==========================================
// memory end of the link
module ees_mem #(
	parameter int ERASE_CYC = `EES_ERASE_CYC,  // erase duration in link_clk cycles
	parameter int WRITE_CYC = `EES_WRITE_CYC   // write duration in link_clk cycles
) (
	input  wire logic link_clk,  // memory clock, samples the link
	input  wire logic reset_n,   // async reset, active low
	ees_link_if.dev   link,      // two-wire link
	output logic      busy,      // programming in progress
	output logic      standby    // memory in standby
);

	// ==========================================
	// helpers
	function automatic logic [7:0] byte_of(input logic [15:0] w, input logic hi);
		byte_of = hi ? w[15:8] : w[7:0];
	endfunction

	function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
		input logic [7:0] b);
		put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
	endfunction

	function automatic logic [4:0] step_row(input logic [4:0] r, input logic down);
		step_row = down ? r - 5'h01 : r + 5'h01;  // 5-bit wrap
	endfunction

	function automatic logic is_fill(input logic [1:0] m);
		is_fill = (m == `EES_MODE_FILL0) || (m == `EES_MODE_FILL1);
	endfunction

	// first bit on the line of the selected byte
	function automatic logic msb_of(input logic [15:0] w, input logic hi);
		msb_of = hi ? w[15] : w[7];
	endfunction

	// ==========================================
	// state
	logic [`EES_WORD_W-1:0] mem [`EES_ROWS];
	logic [1:0]             scl_sync_q;
	logic [1:0]             sda_sync_q;
	logic                   scl_p_q;
	logic                   sda_p_q;
	ees_pkg::ees_dev_state_t state_q;
	ees_pkg::ees_prog_state_t pstate_q;
	logic [7:0]             sh_q;
	logic [2:0]             cnt_q;
	logic                   full_q;
	logic [4:0]             row_q;
	logic [1:0]             mode_q;
	logic                   dir_q;
	logic                   hi_q;
	logic [1:0]             nbytes_q;
	logic [15:0]            buf_q;
	logic                   oe_q;
	logic                   acked_q;
	logic                   wr_ok_q;
	logic                   prog_go_q;
	logic                   busy_q;
	logic                   standby_q;
	logic [15:0]            pcnt_q;
	logic                   scl_s;
	logic                   sda_s;
	logic                   start_ev;
	logic                   stop_ev;
	logic                   rise;
	logic                   fall;
	logic                   erase_end;
	logic                   write_end;
	logic                   fill;

	assign link.dev_sda_oe = oe_q;
	assign busy            = busy_q;
	assign standby         = standby_q;

	// ==========================================
	// pin synchronisers
	always_ff @(posedge link_clk or negedge reset_n)
		if (!reset_n)
		begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_p_q    <= 1'b1;
			sda_p_q    <= 1'b1;
		end
		else
		begin
			scl_sync_q <= {scl_sync_q[0], link.scl};
			sda_sync_q <= {sda_sync_q[0], link.sda};
			scl_p_q    <= scl_s;
			sda_p_q    <= sda_s;
		end

	// line events
	assign scl_s    = scl_sync_q[1];
	assign sda_s    = sda_sync_q[1];
	assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign rise     = scl_s & ~scl_p_q;
	assign fall     = ~scl_s & scl_p_q;

	// ==========================================
	// link protocol
	always_ff @(posedge link_clk or negedge reset_n)
		if (!reset_n)
		begin
			state_q   <= ees_pkg::DEV_STANDBY;
			sh_q      <= 8'h00;
			cnt_q     <= 3'h0;
			full_q    <= 1'b0;
			row_q     <= 5'h00;
			mode_q    <= 2'h0;
			dir_q     <= 1'b0;
			hi_q      <= 1'b0;
			nbytes_q  <= 2'h0;
			buf_q     <= 16'h0000;
			oe_q      <= 1'b0;
			acked_q   <= 1'b0;
			wr_ok_q   <= 1'b0;
			prog_go_q <= 1'b0;
			standby_q <= 1'b1;
		end
		else if (start_ev)
		begin
			// conditions take priority over any bit
			state_q   <= ees_pkg::DEV_CTRL;
			standby_q <= 1'b0;
			cnt_q     <= 3'h0;
			full_q    <= 1'b0;
			nbytes_q  <= 2'h0;
			oe_q      <= 1'b0;
			wr_ok_q   <= 1'b0;
			prog_go_q <= 1'b0;
		end
		else if (stop_ev)
		begin
			state_q   <= ees_pkg::DEV_STANDBY;
			standby_q <= 1'b1;
			oe_q      <= 1'b0;
			wr_ok_q   <= 1'b0;
			prog_go_q <= wr_ok_q & ((nbytes_q != 2'h0) | is_fill(mode_q));
		end
		else
		begin
			prog_go_q <= 1'b0;
			unique case (state_q)
				ees_pkg::DEV_STANDBY, ees_pkg::DEV_IGNORE:
					oe_q <= 1'b0;
				ees_pkg::DEV_CTRL, ees_pkg::DEV_WRX:
				begin
					if (rise)
					begin
						// msb first, sampled while clock high
						sh_q   <= {sh_q[6:0], sda_s};
						cnt_q  <= cnt_q + 3'h1;
						full_q <= (cnt_q == `EES_BYTE_LAST);
					end
					else if (fall && full_q && state_q == ees_pkg::DEV_CTRL)
					begin
						full_q <= 1'b0;
						if (busy_q)
							state_q <= ees_pkg::DEV_IGNORE;
						else
						begin
							row_q   <= sh_q[7:`EES_ROW_LSB];
							mode_q  <= sh_q[`EES_MODE_LSB +: 2];
							dir_q   <= sh_q[`EES_DIR_POS];
							hi_q    <= sh_q[`EES_MODE_LSB + 1];
							wr_ok_q <= sh_q[`EES_DIR_POS] != `EES_DIR_READ;
							buf_q   <= mem[sh_q[7:`EES_ROW_LSB]];
							oe_q    <= 1'b1;
							state_q <= ees_pkg::DEV_ACK_C;
						end
					end
					else if (fall && full_q)
					begin
						full_q <= 1'b0;
						if (nbytes_q == `EES_MAX_WR_BYTES)
							state_q <= ees_pkg::DEV_IGNORE;
						else
						begin
							buf_q    <= put_byte(buf_q, hi_q, sh_q);
							hi_q     <= ~hi_q;
							nbytes_q <= nbytes_q + 2'h1;
							oe_q     <= 1'b1;
							state_q  <= ees_pkg::DEV_ACK_W;
						end
					end
				end
				ees_pkg::DEV_ACK_C:
					if (fall)
					begin
						cnt_q <= 3'h0;
						if (dir_q == `EES_DIR_READ)
						begin
							// first selected byte goes out
							sh_q    <= byte_of(buf_q, hi_q);
							oe_q    <= ~msb_of(buf_q, hi_q);
							state_q <= ees_pkg::DEV_TX;
						end
						else
						begin
							oe_q    <= 1'b0;
							state_q <= is_fill(mode_q) ? ees_pkg::DEV_IGNORE : ees_pkg::DEV_WRX;
						end
					end
				ees_pkg::DEV_ACK_W:
					if (fall)
					begin
						oe_q    <= 1'b0;
						state_q <= ees_pkg::DEV_WRX;
					end
				ees_pkg::DEV_TX:
					if (fall)
					begin
						if (cnt_q == `EES_BYTE_LAST)
						begin
							oe_q    <= 1'b0;  // host answers in ninth bit
							acked_q <= 1'b0;
							state_q <= ees_pkg::DEV_ACK_R;
						end
						else
						begin
							sh_q  <= {sh_q[6:0], 1'b0};
							oe_q  <= ~sh_q[6];
							cnt_q <= cnt_q + 3'h1;
						end
					end
				ees_pkg::DEV_ACK_R:
					if (rise)
					begin
						if (sda_s)
							state_q <= ees_pkg::DEV_IGNORE;
						else
						begin
							acked_q <= 1'b1;
							hi_q    <= ~hi_q;
							if (hi_q != mode_q[1])
							begin
								// word done: step, wrap, reload
								row_q <= step_row(row_q, mode_q[1]);
								buf_q <= mem[step_row(row_q, mode_q[1])];
							end
						end
					end
					else if (fall && acked_q)
					begin
						sh_q    <= byte_of(buf_q, hi_q);
						oe_q    <= ~msb_of(buf_q, hi_q);
						cnt_q   <= 3'h0;
						state_q <= ees_pkg::DEV_TX;
					end
			endcase
		end

	// ==========================================
	// internal programming timer
	assign erase_end = (pstate_q == ees_pkg::PRG_ERASE) && (pcnt_q == 16'(ERASE_CYC - 1));
	assign write_end = (pstate_q == ees_pkg::PRG_WRITE) && (pcnt_q == 16'(WRITE_CYC - 1));
	assign fill      = is_fill(mode_q);

	always_ff @(posedge link_clk or negedge reset_n)
		if (!reset_n)
		begin
			pstate_q <= ees_pkg::PRG_IDLE;
			pcnt_q   <= 16'h0000;
			busy_q   <= 1'b0;
		end
		else
		begin
			pcnt_q <= (erase_end || prog_go_q) ? 16'h0000 : pcnt_q + 16'h0001;
			unique case (pstate_q)
				ees_pkg::PRG_IDLE:
					if (prog_go_q)
					begin
						pstate_q <= ees_pkg::PRG_ERASE;
						busy_q   <= 1'b1;
					end
				ees_pkg::PRG_ERASE:
					if (erase_end)
						pstate_q <= ees_pkg::PRG_WRITE;
				ees_pkg::PRG_WRITE:
					if (write_end)
					begin
						pstate_q <= ees_pkg::PRG_IDLE;
						busy_q   <= 1'b0;
					end
			endcase
		end

	// array update: erase to zeros, then write word, or in fill mode the fill value to all rows
	always_ff @(posedge link_clk)
		if (erase_end)
		begin
			for (int i = 0; i < `EES_ROWS; i++)
				if (fill || row_q == 5'(i))
					mem[i] <= 16'h0000;
		end
		else if (write_end)
		begin
			for (int i = 0; i < `EES_ROWS; i++)
				if (fill)
					mem[i] <= {16{mode_q[0]}};
				else if (row_q == 5'(i))
					mem[i] <= buf_q;
		end

endmodule // ees_mem

// file: verilog/ees_host.sv
`timescale 1ns/10ps
`include "ees_defs.svh"
// ==========================================
// host end: sole master of the link
module ees_host (
	input  wire logic        clk,        // system clock
	input  wire logic        reset_n,    // async reset, active low
	ees_link_if.host         link,       // two-wire link
	input  wire logic        cmd_valid,  // transfer request
	output logic             cmd_ready,  // idle, request taken
	input  wire logic [7:0]  cmd_ctrl,   // control byte
	input  wire logic [1:0]  cmd_len,    // data bytes after control
	input  wire logic [15:0] cmd_wdata,  // write bytes, first in [7:0]
	output logic             rd_valid,   // read byte pulse
	output logic [7:0]       rd_data,    // read byte
	output logic             done,       // transfer end pulse
	output logic             ack_fail    // memory did not acknowledge
);

	ees_pkg::ees_host_state_t state_q;
	logic [7:0]  qcnt_q;
	logic [1:0]  ph_q;
	logic [3:0]  bit_q;
	logic [1:0]  idx_q;
	logic [7:0]  ctrl_q;
	logic [1:0]  len_q;
	logic [15:0] wdata_q;
	logic [7:0]  tx_q;
	logic [7:0]  rx_q;
	logic        ackbit_q;
	logic        scl_q;
	logic        oe_q;
	logic [1:0]  sda_sync_q;
	logic        ready_q;
	logic        rd_valid_q;
	logic [7:0]  rd_data_q;
	logic        done_q;
	logic        fail_q;
	logic        tick;
	logic        rxmode;

	assign link.scl         = scl_q;
	assign link.host_sda_oe = oe_q;
	assign cmd_ready        = ready_q;
	assign rd_valid         = rd_valid_q;
	assign rd_data          = rd_data_q;
	assign done             = done_q;
	assign ack_fail         = fail_q;

	// quarter bit divider
	assign tick   = qcnt_q == 8'(`EES_SCL_QTR_CYC - 1);
	assign rxmode = ctrl_q[`EES_DIR_POS] && (idx_q != 2'h0);

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			qcnt_q <= 8'h00;
		else
			qcnt_q <= tick ? 8'h00 : qcnt_q + 8'h01;

	// data line synchroniser
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			sda_sync_q <= 2'h3;
		else
			sda_sync_q <= {sda_sync_q[0], link.sda};

	// ==========================================
	// transfer sequencer
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			state_q    <= ees_pkg::HST_IDLE;
			ph_q       <= 2'h0;
			bit_q      <= 4'h0;
			idx_q      <= 2'h0;
			ctrl_q     <= 8'h00;
			len_q      <= 2'h0;
			wdata_q    <= 16'h0000;
			tx_q       <= 8'h00;
			rx_q       <= 8'h00;
			ackbit_q   <= 1'b1;
			scl_q      <= 1'b1;
			oe_q       <= 1'b0;
			ready_q    <= 1'b1;
			rd_valid_q <= 1'b0;
			rd_data_q  <= 8'h00;
			done_q     <= 1'b0;
			fail_q     <= 1'b0;
		end
		else
		begin
			rd_valid_q <= 1'b0;
			done_q     <= 1'b0;
			unique case (state_q)
				ees_pkg::HST_IDLE:
					if (cmd_valid && ready_q)
					begin
						ready_q <= 1'b0;
						ctrl_q  <= cmd_ctrl;
						len_q   <= cmd_len;
						wdata_q <= cmd_wdata;
						fail_q  <= 1'b0;
						ph_q    <= 2'h0;
						state_q <= ees_pkg::HST_START;
					end
				ees_pkg::HST_START:
					if (tick)
					begin
						ph_q <= ph_q + 2'h1;
						if (ph_q == 2'h0)
							oe_q <= 1'b1;
						else
						begin
							scl_q   <= 1'b0;
							ph_q    <= 2'h0;
							bit_q   <= 4'h0;
							idx_q   <= 2'h0;
							tx_q    <= ctrl_q;
							state_q <= ees_pkg::HST_BIT;
						end
					end
				ees_pkg::HST_BIT:
					if (tick)
					begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0:
								// drive while clock low
								if (bit_q == `EES_ACK_BIT)
									oe_q <= rxmode && (idx_q != len_q);
								else
									oe_q <= rxmode ? 1'b0 : ~tx_q[7];
							2'h1:
								scl_q <= 1'b1;
							2'h2:
								if (bit_q == `EES_ACK_BIT)
									ackbit_q <= sda_sync_q[1];
								else
									rx_q <= {rx_q[6:0], sda_sync_q[1]};
							2'h3:
							begin
								scl_q <= 1'b0;
								if (bit_q != `EES_ACK_BIT)
								begin
									bit_q <= bit_q + 4'h1;
									tx_q  <= {tx_q[6:0], 1'b0};
								end
								else
								begin
									bit_q      <= 4'h0;
									rd_valid_q <= rxmode;
									rd_data_q  <= rx_q;
									if (!rxmode && ackbit_q)
									begin
										fail_q  <= 1'b1;
										state_q <= ees_pkg::HST_STOP;
									end
									else if (idx_q == len_q)
										state_q <= ees_pkg::HST_STOP;
									else
									begin
										idx_q <= idx_q + 2'h1;
										tx_q  <= (idx_q == 2'h0) ? wdata_q[7:0] : wdata_q[15:8];
									end
								end
							end
						endcase
					end
				ees_pkg::HST_STOP:
					if (tick)
					begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0: oe_q  <= 1'b1;
							2'h1: scl_q <= 1'b1;
							2'h2: oe_q  <= 1'b0;
							2'h3:
							begin
								state_q <= ees_pkg::HST_IDLE;
								ready_q <= 1'b1;
								done_q  <= 1'b1;
							end
						endcase
					end
			endcase
		end

endmodule // ees_host

// file: dv/ees_link_monitor.sv
`timescale 1ns/10ps
// ==========================================
// link checker beside the host to memory link
module ees_link_monitor (
	input wire logic clk,          // host clock
	input wire logic link_clk,     // memory clock
	input wire logic reset_n,      // async reset, active low
	input wire logic scl,          // serial clock
	input wire logic host_sda_oe,  // host pulls data low
	input wire logic dev_sda_oe,   // memory pulls data low
	input wire logic sda,          // resolved data line
	input wire logic busy,         // programming in progress
	input wire logic standby       // memory in standby
);
	logic       scl_q;
	logic [7:0] gap_q;

	// clk cycles since the last serial clock edge, saturating
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scl_q <= 1'b1;
			gap_q <= 8'hff;
		end
		else
		begin
			scl_q <= scl;
			if (scl != scl_q)
				gap_q <= 8'h00;
			else if (gap_q != 8'hff)
				gap_q <= gap_q + 8'h01;
		end
	end

	// ==========================================
	// assertions
	a_scl_edge_gap: assert property (@(posedge clk) disable iff (!reset_n)
		(scl != scl_q) |-> (gap_q >= 8'h5a)) else $error("serial clock edges too close");
	a_dev_data_stable: assert property (@(posedge link_clk) disable iff (!reset_n)
		(scl && $past(scl)) |-> $stable(dev_sda_oe)) else $error("memory moved data in high");
	a_start_wakes: assert property (@(posedge link_clk) disable iff (!reset_n)
		(scl && $past(scl) && $fell(sda)) |-> ##[1:8] !standby)
		else $error("start did not wake memory");
	a_stop_sleeps: assert property (@(posedge link_clk) disable iff (!reset_n)
		(scl && $past(scl) && $rose(sda)) |-> ##[1:8] standby)
		else $error("stop did not return standby");
	a_standby_quiet: assert property (@(posedge link_clk) disable iff (!reset_n)
		standby |-> !dev_sda_oe) else $error("memory drives data in standby");
	a_busy_quiet: assert property (@(posedge link_clk) disable iff (!reset_n)
		busy |-> !dev_sda_oe) else $error("busy memory drives data");
	a_busy_after_stop: assert property (@(posedge link_clk) disable iff (!reset_n)
		$rose(busy) |-> standby) else $error("programming began inside a frame");
	a_low_holds: assert property (@(posedge link_clk) disable iff (!reset_n)
		$rose(dev_sda_oe) |-> dev_sda_oe[*8]) else $error("memory low bit too short");
	a_host_start_form: assert property (@(posedge clk) disable iff (!reset_n)
		(scl && $rose(host_sda_oe)) |-> ##[1:60] !scl)
		else $error("host moved data in clock high");
endmodule // ees_link_monitor

// file: dv/ees_tb_top.sv
`timescale 1ns/10ps
// ==========================================
// bench: host and memory joined over the link
module ees_tb_top;
	logic        clk;
	logic        link_clk;
	logic        reset_n;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [7:0]  cmd_ctrl;
	logic [1:0]  cmd_len;
	logic [15:0] cmd_wdata;
	logic        rd_valid;
	logic [7:0]  rd_data;
	logic        done;
	logic        ack_fail;
	logic        busy;
	logic        standby;
	logic [7:0]  rd_q[$];
	int          errors;
	int          num_checks;

	ees_link_if link ();

	ees_host u_ees_host (.clk(clk), .reset_n(reset_n), .link(link.host),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_ctrl(cmd_ctrl),
		.cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid),
		.rd_data(rd_data), .done(done), .ack_fail(ack_fail));

	ees_mem #(.ERASE_CYC(1000), .WRITE_CYC(1000)) u_ees_mem (.link_clk(link_clk),
		.reset_n(reset_n), .link(link.dev), .busy(busy), .standby(standby));

	ees_link_monitor u_ees_link_monitor (.clk(clk), .link_clk(link_clk),
		.reset_n(reset_n), .scl(link.scl), .host_sda_oe(link.host_sda_oe),
		.dev_sda_oe(link.dev_sda_oe), .sda(link.sda), .busy(busy), .standby(standby));

	// clocks, unrelated in phase
	initial clk = 1'b0;
	always #5 clk = ~clk;
	initial
	begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	// collect read bytes, mid cycle
	always @(negedge clk)
		if (rd_valid === 1'b1)
			rd_q.push_back(rd_data);

	// ==========================================
	// shared tasks
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one host transfer, waits for its end
	task automatic do_cmd(input logic [7:0] ctrl, input logic [1:0] len, input logic [15:0] wd);
		int n;
		n = 0;
		rd_q.delete();
		while (cmd_ready !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		cmd_ctrl = ctrl;
		cmd_len = len;
		cmd_wdata = wd;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		check({15'h0, cmd_ready}, 16'h0000);
		n = 0;
		while (done !== 1'b1 && n < 20000)
		begin
			@(negedge clk);
			n++;
		end
		check({15'h0, done}, 16'h0001);
		check({15'h0, standby}, 16'h0001);
	endtask

	// wait out a programming cycle
	task automatic wait_prog();
		int n;
		n = 0;
		while (busy !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		check({15'h0, busy}, 16'h0001);
		n = 0;
		while (busy !== 1'b0 && n < 5000)
		begin
			@(negedge clk);
			n++;
		end
		check({15'h0, busy}, 16'h0000);
	endtask

	// ==========================================
	// scenarios
	// control byte alone, no programming follows
	task automatic t_ctrl_only();
		do_cmd(8'h52, 2'h0, 16'h0000);
		check({15'h0, ack_fail}, 16'h0000);
		check({15'h0, busy}, 16'h0000);
	endtask

	// write low byte first, then poll while programming
	task automatic t_write_poll();
		do_cmd(8'h2a, 2'h2, 16'h1234);
		check({15'h0, ack_fail}, 16'h0000);
		do_cmd(8'h2a, 2'h0, 16'h0000);
		check({15'h0, ack_fail}, 16'h0001);
		wait_prog();
	endtask

	// rows for the reads: high first, low first, top row
	task automatic t_write_rows();
		logic [7:0]  c [3] = '{8'h34, 8'h02, 8'hfa};
		logic [15:0] w [3] = '{16'h7856, 16'hdef0, 16'h9abc};
		for (int i = 0; i < 3; i++)
		begin
			do_cmd(c[i], 2'h2, w[i]);
			check({15'h0, ack_fail}, 16'h0000);
			wait_prog();
		end
	endtask

	// three byte read crossing a word boundary
	task automatic t_read(input logic [7:0] ctrl, input logic [23:0] exp);
		do_cmd(ctrl, 2'h3, 16'h0000);
		check({15'h0, ack_fail}, 16'h0000);
		check(16'(rd_q.size()), 16'h0003);
		for (int i = 0; i < 3 && i < rd_q.size(); i++)
			check({8'h00, rd_q[i]}, {8'h00, exp[23 - 8 * i -: 8]});
	endtask

	// single byte write used to force a known state
	task automatic t_dummy_init();
		do_cmd(8'h52, 2'h1, 16'h00a5);
		check({15'h0, ack_fail}, 16'h0000);
		wait_prog();
	endtask

	// whole array fill by mode code, then one byte read back
	task automatic t_fill(input logic [7:0] fc, input logic [7:0] rc, input logic [7:0] exp);
		do_cmd(fc, 2'h0, 16'h0000);
		check({15'h0, ack_fail}, 16'h0000);
		wait_prog();
		do_cmd(rc, 2'h1, 16'h0000);
		check(16'(rd_q.size()), 16'h0001);
		if (rd_q.size() > 0)
			check({8'h00, rd_q[0]}, {8'h00, exp});
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		errors = 0;
		num_checks = 0;
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_ctrl = 8'h00;
		cmd_len = 2'h0;
		cmd_wdata = 16'h0000;
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		t_ctrl_only();
		t_write_poll();
		t_write_rows();
		t_read(8'h2b, 24'h341278);
		t_read(8'h05, 24'hdef09a);
		t_fill(8'h06, 8'h3b, 8'hff);
		t_fill(8'h00, 8'h3b, 8'h00);
		t_dummy_init();
		report_and_stop();
	end

	// watchdog against a hung link
	initial
	begin
		#900000;
		errors++;
		report_and_stop();
	end
endmodule // ees_tb_top
